// File: hdl/hdlc_rx_pkg.sv
// Behaviour
// - Line port detects mark idle, optionally inverts data, selects programmed slot.
// - Inside a frame, a zero after five ones is deleted.
// - Four-bit short counter; short flag when closed frame below minimum with bytes stored.
// - Packet status becomes visible only when the packet's last byte leaves the FIFO.
// - At closing flag checker state examined; mismatch sets checksum error bit 2.
// - Keep-checksum control set stores received check bytes; clear discards them.
// - Destuffed bits pass a 32-bit shift register, delivering bytes to the FIFO.
// - Filtering compares leading address bytes to four addresses plus broadcast; mismatch drops frame.
// - Optionally the command/response bit 1 of first address byte is ignored.
// - Address control bits 4 to 0 all zero disables filtering.
// - Byte-ready flag set while output holds data; clears when read empties FIFO.
// - Level signal high when occupancy reaches threshold bits 7 to 4; feeds request.
// - DMA request at threshold or last byte stored; ends at empty or last removed.
// - Byte-ready drops at last byte removal; stays low until count low read.
// - Byte counter counts packet bytes read out; copied to count register at last removal.
// - Reaching maximum size before closing flag marks that byte last, sets oversize flag.
// - Eight bits make a byte; other count at closing flag records residue, delayed.
// - Partial final byte is right-justified before entering the FIFO.
// - Transparent mode bypasses flags, checksum and deletion; raw bytes stored while enabled.
// - Transparent mode one stops requests after maximum count stored; done flag at read-out.
// - Transparent mode two runs while enabled; clearing stops requests; no byte is marked last, so the done flag never sets.
// - Multiplexed transparent mode takes seven bits per slot, still eight per byte.
// - Check sequence uses x^16+x^12+x^5+1 over unstuffed bits between flags.
// - Multiplexed mode takes one programmed slot of 32; plain mode takes every bit.
package hdlc_rx_pkg;
	localparam int          FIFO_DEPTH    = 32;
	localparam int          BUF_DEPTH     = 4;
	localparam int          ENTRY_W       = 9;
	localparam logic [15:0] CRC_POLY      = 16'h1021;
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_GOOD      = 16'h1D0F;
	localparam logic [7:0]  FLAG_BYTE     = 8'h7E;
	localparam logic [7:0]  BCAST_ADDR    = 8'hFF;
	localparam int          STUFF_ONES    = 5;
	localparam int          ABORT_ONES    = 7;
	localparam int          IDLE_ONES     = 15;
	localparam int          BITS_PER_BYTE = 8;
	localparam int          BITS_56K      = 7;
	localparam int          SLOT_BITS     = 8;
	localparam int          CRC_ERR_BIT   = 2;
	localparam int          KEEP_FCS_BIT  = 7;
	localparam int          CR_BIT        = 1;
	localparam int          TRANS_BIT     = 7;
	localparam int          TMODE1_BIT    = 6;
	typedef logic [ENTRY_W-1:0] entry_t;
endpackage : hdlc_rx_pkg

// File: hdl/byte_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 9);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// File: hdl/rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic           clk_sys_i,
	input  wire logic           reset_n_i,
	input  wire logic           flush_i,
	// Streams
	byte_stream_if.dst          in_s,
	byte_stream_if.src          out_s,
	// Occupancy
	output logic [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	assign in_s.ready  = (count != (AW+1)'(DEPTH));
	assign out_s.valid = (count != '0);
	assign out_s.data  = mem[rd_ptr];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;
	assign level_o     = count;

	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem[wr_ptr] <= in_s.data;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (flush_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : rx_fifo
`default_nettype wire

// File: hdl/hdlc_frame_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_frame_receiver (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	// Line port
	input  wire logic        serial_line_in_i,
	input  wire logic        line_clk_i,
	input  wire logic        slot_sync_i,
	// Control
	input  wire logic        rx_on_i,
	input  wire logic        invert_i,
	input  wire logic        mux_mode_i,
	input  wire logic [4:0]  slot_sel_i,
	input  wire logic [7:0]  cmd_ctrl_i,
	input  wire logic [7:0]  residual_ctrl_i,
	input  wire logic [7:0]  addr_ctrl_i,
	input  wire logic        ignore_cr_i,
	input  wire logic [7:0]  addr0_i,
	input  wire logic [7:0]  addr1_i,
	input  wire logic [7:0]  addr2_i,
	input  wire logic [7:0]  addr3_i,
	input  wire logic [3:0]  min_size_i,
	input  wire logic [7:0]  max_size_i,
	input  wire logic [7:0]  threshold_i,
	// Host read side
	input  wire logic        data_rd_i,
	input  wire logic        count_lo_rd_i,
	output logic [7:0]       rx_data_o,
	output logic             rx_byte_ready_o,
	output logic             rx_level_hit_o,
	output logic             rx_dma_request_o,
	output logic             eop_stored_o,
	// Delayed packet status, then live mark idle
	output logic [7:0]       frame_status_o,
	output logic [7:0]       byte_count_o,
	output logic [2:0]       residue_o,
	output logic             rx_done_flag_o,
	output logic             mark_idle_o
);
	import hdlc_rx_pkg::*;

	// Two-flop sync of link pins
	logic [2:0] s1, s2;
	logic       clk_d;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s1    <= '0;
			s2    <= '0;
			clk_d <= 1'b0;
		end
		else
		begin
			s1    <= {slot_sync_i, line_clk_i, serial_line_in_i};
			s2    <= s1;
			clk_d <= s2[1];
		end
	end
	logic bit_edge;
	logic line_bit;
	assign bit_edge = s2[1] && !clk_d;
	assign line_bit = s2[0] ^ invert_i;

	// Slot position: 32 slots of 8 bits after sync
	logic [4:0] slot_no;
	logic [2:0] slot_bit;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			slot_no  <= '0;
			slot_bit <= '0;
		end
		else if (bit_edge)
		begin
			if (s2[2])
			begin
				slot_no  <= '0;
				slot_bit <= 3'd1;
			end
			else
			begin
				slot_bit <= slot_bit + 3'd1;
				if (slot_bit == 3'(SLOT_BITS-1))
					slot_no <= slot_no + 5'd1;
			end
		end
	end
	logic transparent;
	logic tmode1;
	logic in_slot;
	logic take_bit;
	logic [2:0] cur_bit;
	assign transparent = residual_ctrl_i[TRANS_BIT];
	assign tmode1      = residual_ctrl_i[TMODE1_BIT];
	assign cur_bit     = s2[2] ? 3'd0 : slot_bit;
	assign in_slot     = s2[2] ? (slot_sel_i == 5'd0) : (slot_no == slot_sel_i);
	// Eighth bit (bit 7) of each slot dropped in 56k mode
	assign take_bit = bit_edge && (!mux_mode_i || (in_slot &&
		!(transparent && cur_bit == 3'(BITS_56K))));

	// Flag, abort, destuffing
	typedef enum {HUNT, SYNC, DATA, DROP} rx_state_e;
	rx_state_e   state;
	logic [3:0]  ones;
	logic [7:0]  hist;
	logic [31:0] shreg;
	logic [2:0]  bitcnt;
	logic [15:0] crc;
	logic        flag_seen;
	logic        abort_seen;
	logic        stuffed;
	logic [3:0]  next_ones;
	logic [15:0] next_crc;
	assign next_ones  = line_bit ? ((ones == 4'd15) ? ones : ones + 4'd1) : 4'd0;
	assign flag_seen  = !transparent && ({hist[6:0], line_bit} == FLAG_BYTE);
	assign abort_seen = !transparent && next_ones >= 4'(ABORT_ONES);
	assign stuffed    = !transparent && !line_bit && ones == 4'(STUFF_ONES);
	// Checker lags seven bits so the flag head never enters it
	assign next_crc   = {crc[14:0], 1'b0} ^ ((crc[15] ^ shreg[25]) ? CRC_POLY : 16'h0000);

	// Byte pipeline into FIFO
	logic [3:0]  short_cnt;
	logic [7:0]  pkt_cnt;
	logic [1:0]  addr_idx;
	logic        tr_stop;
	logic        byte_done;
	logic [7:0]  new_byte;
	logic        addr_ok;
	logic        pend_v;
	logic [7:0]  pend;
	entry_t      em [4];
	logic [2:0]  em_n;
	entry_t      close_e [4];
	logic [2:0]  close_n;
	logic [4:0]  fill;
	logic [7:0]  dbyte;
	logic        em_pop;
	logic [7:0]  st_bits;
	logic [2:0]  st_res;
	assign byte_done = take_bit && !transparent && !abort_seen && !flag_seen && !stuffed
		&& (state == SYNC || state == DATA) && fill == 5'd23 && bitcnt == 3'(BITS_PER_BYTE-1);
	assign new_byte  = {shreg[9], dbyte[7:1]};

	// Closing entries: held byte, right-justified residue, optional check bytes
	always_comb
	begin
		close_n = '0;
		close_e = '{default: '0};
		if (pend_v)
		begin
			close_e[0] = {1'b0, pend};
			close_n    = 3'd1;
		end
		if (bitcnt != 3'd0)
		begin
			close_e[close_n[1:0]] = {1'b0, dbyte >> (4'd8 - {1'b0, bitcnt})};
			close_n               = close_n + 3'd1;
		end
		if (cmd_ctrl_i[KEEP_FCS_BIT])
		begin
			close_e[close_n[1:0]]        = {1'b0, shreg[16:9]};
			close_e[close_n[1:0] + 2'd1] = {1'b0, shreg[24:17]};
			close_n                      = close_n + 3'd2;
		end
		if (close_n != 3'd0)
			close_e[close_n[1:0] - 2'd1][8] = 1'b1;
	end

	function automatic logic match(input logic [7:0] b, input logic [7:0] a, input logic cr);
		logic [7:0] m;
		m = cr ? 8'hFD : 8'hFF;
		return ((b & m) == (a & m));
	endfunction : match
	always_comb
	begin
		addr_ok = (new_byte == BCAST_ADDR)
			|| (addr_ctrl_i[0] && match(new_byte, addr0_i, ignore_cr_i && addr_idx == 2'd0))
			|| (addr_ctrl_i[1] && match(new_byte, addr1_i, ignore_cr_i && addr_idx == 2'd0))
			|| (addr_ctrl_i[2] && match(new_byte, addr2_i, ignore_cr_i && addr_idx == 2'd0))
			|| (addr_ctrl_i[3] && match(new_byte, addr3_i, ignore_cr_i && addr_idx == 2'd0));
	end
	// Bit 4 selects second byte; bits 4-0 zero disables filter
	logic check_now;
	assign check_now = (addr_ctrl_i[4:0] != 5'd0) && !transparent
		&& ((addr_idx == 2'd0 && addr_ctrl_i[3:0] != 4'd0) || (addr_idx == 2'd1 && addr_ctrl_i[4]));

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state     <= HUNT;
			ones      <= '0;
			hist      <= '0;
			shreg     <= '0;
			bitcnt    <= '0;
			crc       <= CRC_INIT;
			short_cnt <= '0;
			pkt_cnt   <= '0;
			addr_idx  <= '0;
			pend_v    <= 1'b0;
			pend      <= '0;
			em        <= '{default: '0};
			em_n      <= '0;
			fill      <= '0;
			dbyte     <= '0;
			st_bits   <= '0;
			st_res    <= '0;
			tr_stop   <= 1'b0;
		end
		else
		begin
			// Pops happen only off bit cycles, so they never meet an append
			if (em_pop)
			begin
				em[0] <= em[1];
				em[1] <= em[2];
				em[2] <= em[3];
				em_n  <= em_n - 3'd1;
			end
			if (!rx_on_i)
				tr_stop <= 1'b0;
			if (!rx_on_i)
				state <= HUNT;
			else if (take_bit)
			begin
				ones <= next_ones;
				hist <= {hist[6:0], line_bit};
				if (transparent)
				begin
					shreg  <= {line_bit, shreg[31:1]};
					bitcnt <= bitcnt + 3'd1;
					if (bitcnt == 3'(BITS_PER_BYTE-1) && !tr_stop && em_n != 3'd4)
					begin
						pkt_cnt       <= pkt_cnt + 8'd1;
						em_n          <= em_n + 3'd1;
						em[em_n[1:0]] <= {tmode1 && pkt_cnt + 8'd1 == max_size_i, line_bit, shreg[31:25]};
						if (tmode1 && pkt_cnt + 8'd1 == max_size_i)
							tr_stop <= 1'b1;
					end
				end
				else if (abort_seen)
					state <= HUNT;
				else if (flag_seen)
				begin
					// Closing flag: the window holds check bytes and flag head
					if (state == DATA && fill == 5'd23 && close_n != 3'd0)
					begin
						st_bits <= '0;
						st_bits[CRC_ERR_BIT] <= (crc != CRC_GOOD);
						st_bits[0] <= (short_cnt < min_size_i);
						st_bits[3] <= (bitcnt != 3'd0);
						st_res  <= bitcnt;
						// Queue is empty here: it drains within a bit time
						em      <= close_e;
						em_n    <= close_n;
						pend_v  <= 1'b0;
					end
					state    <= SYNC;
					bitcnt   <= '0;
					fill     <= '0;
					crc      <= CRC_INIT;
					short_cnt <= '0;
					pkt_cnt  <= '0;
					addr_idx <= '0;
				end
				else if ((state == SYNC || state == DATA) && !stuffed)
				begin
					state  <= DATA;
					shreg  <= {line_bit, shreg[31:1]};
					// 23-bit lag hides check sequence and flag head until the frame ends
					if (fill != 5'd23)
						fill <= fill + 5'd1;
					if (fill >= 5'd7)
						crc <= next_crc;
					if (fill == 5'd23)
					begin
						dbyte  <= new_byte;
						bitcnt <= bitcnt + 3'd1;
					end
					if (byte_done)
					begin
						if (short_cnt != 4'hF)
							short_cnt <= short_cnt + 4'd1;
						if (addr_idx != 2'd2)
							addr_idx <= addr_idx + 2'd1;
						if (check_now && !addr_ok)
							state <= DROP;
						else
						begin
							pend_v <= 1'b1;
							pend   <= new_byte;
							if (pend_v)
							begin
								em[em_n[1:0]] <= {pkt_cnt + 8'd1 == max_size_i, pend};
								em_n          <= em_n + 3'd1;
								pkt_cnt       <= pkt_cnt + 8'd1;
								if (pkt_cnt + 8'd1 == max_size_i)
								begin
									st_bits <= 8'h02;
									st_res  <= '0;
									state   <= DROP;
								end
							end
						end
					end
				end
			end
			if (state == HUNT || state == DROP)
				pend_v <= 1'b0;
		end
	end

	// Mark idle outside a frame
	logic [3:0] idle_cnt;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			idle_cnt <= '0;
		else if (take_bit)
			idle_cnt <= line_bit ? ((idle_cnt == 4'(IDLE_ONES)) ? idle_cnt : idle_cnt + 4'd1) : '0;
	end
	assign mark_idle_o = (idle_cnt == 4'(IDLE_ONES)) && state != DATA;

	// Small stage buffer, then 32-byte packet FIFO
	byte_stream_if #(.W(ENTRY_W)) stg_in ();
	byte_stream_if #(.W(ENTRY_W)) stg_out ();
	byte_stream_if #(.W(ENTRY_W)) main_out ();
	assign stg_in.valid = (em_n != 3'd0) && !take_bit;
	assign stg_in.data  = em[0];
	assign em_pop       = stg_in.valid && stg_in.ready;
	rx_fifo #(.W(ENTRY_W), .DEPTH(BUF_DEPTH)) u_stage (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.flush_i   (1'b0),
		.in_s      (stg_in),
		.out_s     (stg_out),
		.level_o   ()
	);
	logic [5:0] level;
	rx_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_main (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.flush_i   (1'b0),
		.in_s      (stg_out),
		.out_s     (main_out),
		.level_o   (level)
	);

	// Host side: status held back until last byte leaves
	logic blocked;
	logic eop_in_fifo;
	logic       pop;
	logic       pop_last;
	logic [7:0] out_cnt;
	assign pop      = data_rd_i && main_out.valid && !blocked;
	assign pop_last = pop && main_out.data[8];
	assign main_out.ready = pop;
	assign rx_data_o = main_out.data[7:0];
	assign rx_byte_ready_o = main_out.valid && !blocked;
	assign rx_level_hit_o  = (level >= {2'b00, threshold_i[7:4]}) && level != '0;
	assign eop_stored_o    = eop_in_fifo;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			blocked        <= 1'b0;
			eop_in_fifo    <= 1'b0;
			out_cnt        <= '0;
			frame_status_o <= '0;
			byte_count_o   <= '0;
			residue_o      <= '0;
			rx_done_flag_o <= 1'b0;
			rx_dma_request_o <= 1'b0;
		end
		else
		begin
			if (stg_out.valid && stg_out.ready && stg_out.data[8])
				eop_in_fifo <= 1'b1;
			else if (pop_last)
				eop_in_fifo <= 1'b0;
			if (pop)
				out_cnt <= pop_last ? 8'd0 : out_cnt + 8'd1;
			if (pop_last)
			begin
				blocked        <= 1'b1;
				byte_count_o   <= out_cnt + 8'd1;
				frame_status_o <= transparent ? 8'h00 : st_bits;
				residue_o      <= st_res;
				rx_done_flag_o <= 1'b1;
			end
			else if (count_lo_rd_i)
			begin
				blocked        <= 1'b0;
				rx_done_flag_o <= 1'b0;
			end
			if (pop_last || (pop && level == 6'd1) || (transparent && !rx_on_i && !tmode1))
				rx_dma_request_o <= 1'b0;
			else if (!blocked && (rx_level_hit_o || eop_in_fifo))
				rx_dma_request_o <= 1'b1;
		end
	end
endmodule : hdlc_frame_receiver
`default_nettype wire

// File: sim/hdlc_line_source.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_line_source
	import hdlc_rx_pkg::*;
(
	// Line outputs
	output logic line_clk_o,
	output logic line_data_o
);
	int ones = 0;
	initial
	begin
		line_clk_o = 1'b0;
		line_data_o = 1'b1;
	end
	// Clock parks low between frames; 10 ns offsets keep every change off the system edges
	task automatic put_bit(input logic b);
		#10;
		line_data_o = b;
		#160;
		line_clk_o = 1'b1;
		#140;
		line_clk_o = 1'b0;
		#10;
	endtask : put_bit
	task automatic send_flag();
		for (int i = 0; i < 8; i++)
			put_bit(FLAG_BYTE[i]);
		ones = 0;
	endtask : send_flag
	// A zero follows five ones so data never looks like a flag
	task automatic send_bits(input logic q[$]);
		foreach (q[i])
		begin
			put_bit(q[i]);
			ones = q[i] ? ones + 1 : 0;
			if (ones == STUFF_ONES)
			begin
				put_bit(1'b0);
				ones = 0;
			end
		end
	endtask : send_bits
	task automatic send_ones(input int n);
		repeat (n) put_bit(1'b1);
	endtask : send_ones
endmodule : hdlc_line_source
`default_nettype wire

// File: sim/hdlc_frame_receiver_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_frame_receiver_properties (
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       reset_n_i,
	// Watched ports
	input wire logic       serial_line_in_i,
	input wire logic       invert_i,
	input wire logic       data_rd_i,
	input wire logic [7:0] rx_data_o,
	input wire logic       rx_byte_ready_o,
	input wire logic       rx_dma_request_o,
	input wire logic [7:0] frame_status_o,
	input wire logic [7:0] byte_count_o,
	input wire logic [2:0] residue_o,
	input wire logic       rx_done_flag_o,
	input wire logic       mark_idle_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	sequence quiet2;
		!data_rd_i ##1 !data_rd_i;
	endsequence
	sequence pop_end;
		data_rd_i && rx_byte_ready_o ##1 !rx_byte_ready_o;
	endsequence
	// Status only moves after a pop, never on its own
	AST_STATUS_HOLD: assert property (quiet2 |=> $stable(frame_status_o))
		else $error("frame status changed without a read");
	AST_COUNT_HOLD: assert property (quiet2 |=> $stable(byte_count_o))
		else $error("byte count changed without a read");
	AST_RESIDUE_HOLD: assert property (quiet2 |=> $stable(residue_o))
		else $error("residue changed without a read");
	AST_HEAD_HOLD: assert property (rx_byte_ready_o && !data_rd_i |=> $stable(rx_data_o))
		else $error("head byte moved without a read");
	AST_REQ_DROP: assert property (pop_end |-> !rx_dma_request_o)
		else $error("request still high after fifo emptied or packet ended");
	AST_RESET_QUIET: assert property ($rose(reset_n_i) |->
		!rx_byte_ready_o && !rx_dma_request_o && frame_status_o == 8'h00)
		else $error("outputs not quiet after reset");
	AST_IDLE_ONES: assert property ($rose(mark_idle_o) |-> $past(serial_line_in_i ^ invert_i, 3))
		else $error("mark idle raised while line low");
	AST_DONE_AFTER_POP: assert property ($rose(rx_done_flag_o) |->
		$past(data_rd_i) || $past(data_rd_i, 2))
		else $error("done flag raised without a read");
endmodule : hdlc_frame_receiver_properties
bind hdlc_frame_receiver hdlc_frame_receiver_properties hdlc_frame_receiver_properties_inst (
	.clk_sys_i, .reset_n_i, .serial_line_in_i, .invert_i, .data_rd_i, .rx_data_o,
	.rx_byte_ready_o, .rx_dma_request_o, .frame_status_o, .byte_count_o, .residue_o,
	.rx_done_flag_o, .mark_idle_o
);
`default_nettype wire

// File: sim/hdlc_frame_receiver_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_frame_receiver_bench;
	import hdlc_rx_pkg::*;
	typedef struct packed
	{
		logic [3:0] n;
		logic [7:0] first;
		logic       bad;
		logic [7:0] actl;
		logic       keep;
		logic [2:0] extra;
		logic       drop;
		logic [7:0] status;
	} row_s;
	localparam int LIMIT = 30000;
	logic       clk_sys_i, reset_n_i, serial_line_in_i, line_clk_i, slot_sync_i;
	logic       rx_on_i, invert_i, mux_mode_i, ignore_cr_i, data_rd_i, count_lo_rd_i;
	logic [4:0] slot_sel_i;
	logic [3:0] min_size_i;
	logic [7:0] cmd_ctrl_i, residual_ctrl_i, addr_ctrl_i, addr0_i, addr1_i, addr2_i, addr3_i;
	logic [7:0] max_size_i, threshold_i, rx_data_o, frame_status_o, byte_count_o;
	logic       rx_byte_ready_o, rx_level_hit_o, rx_dma_request_o, eop_stored_o;
	logic       rx_done_flag_o, mark_idle_o;
	logic [2:0] residue_o;
	logic       abort_bits[$];
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cycles = 0;
	row_s rows [7] = '{
		'{4'h4, 8'hFF, 1'h0, 8'h00, 1'h0, 3'h0, 1'h0, 8'h00},
		'{4'h4, 8'h42, 1'h1, 8'h00, 1'h0, 3'h0, 1'h0, 8'h04},
		'{4'h4, 8'h42, 1'h0, 8'h01, 1'h1, 3'h0, 1'h0, 8'h00},
		'{4'h4, 8'h11, 1'h0, 8'h0F, 1'h0, 3'h0, 1'h1, 8'h00},
		'{4'h1, 8'hFF, 1'h0, 8'h01, 1'h0, 3'h0, 1'h0, 8'h01},
		'{4'h4, 8'h40, 1'h0, 8'h88, 1'h0, 3'h0, 1'h0, 8'h00},
		'{4'h4, 8'hFF, 1'h0, 8'h00, 1'h0, 3'h3, 1'h0, 8'h08}
	};
	hdlc_frame_receiver hdlc_frame_receiver_inst (
		.clk_sys_i, .reset_n_i, .serial_line_in_i, .line_clk_i, .slot_sync_i, .rx_on_i,
		.invert_i, .mux_mode_i, .slot_sel_i, .cmd_ctrl_i, .residual_ctrl_i, .addr_ctrl_i,
		.ignore_cr_i, .addr0_i, .addr1_i, .addr2_i, .addr3_i, .min_size_i, .max_size_i,
		.threshold_i, .data_rd_i, .count_lo_rd_i, .rx_data_o, .rx_byte_ready_o,
		.rx_level_hit_o, .rx_dma_request_o, .eop_stored_o, .frame_status_o, .byte_count_o,
		.residue_o, .rx_done_flag_o, .mark_idle_o
	);
	hdlc_line_source hdlc_line_source_inst (.line_clk_o(line_clk_i), .line_data_o(serial_line_in_i));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Reflected form; transmitted complemented, low bit first
	function automatic logic [15:0] fcs_of(input logic q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i])
			c = (c >> 1) ^ ((c[0] ^ q[i]) ? 16'h8408 : 16'h0000);
		return ~c;
	endfunction : fcs_of
	task automatic run_row(input row_s r);
		logic        q[$];
		logic [7:0]  eb[$];
		logic [7:0]  b;
		logic [15:0] f;
		int          k;
		@(posedge clk_sys_i);
		addr_ctrl_i <= {3'h0, r.actl[4:0]};
		ignore_cr_i <= r.actl[7];
		cmd_ctrl_i <= {r.keep, 7'h00};
		for (int i = 0; i < r.n; i++)
		begin
			b = (i == 0) ? r.first : 8'h3D + 8'(i);
			eb.push_back(b);
			for (int j = 0; j < 8; j++)
				q.push_back(b[j]);
		end
		b = 8'h00;
		for (int j = 0; j < r.extra; j++)
		begin
			b[j] = ~j[0];
			q.push_back(b[j]);
		end
		if (r.extra != 3'h0)
			eb.push_back(b);
		f = fcs_of(q) ^ {15'h0000, r.bad};
		if (r.keep)
			eb = {eb, f[7:0], f[15:8]};
		for (int j = 0; j < 16; j++)
			q.push_back(f[j]);
		while (eb.size() > max_size_i)
			void'(eb.pop_back());
		hdlc_line_source_inst.send_flag();
		hdlc_line_source_inst.send_bits(q);
		hdlc_line_source_inst.send_flag();
		repeat (16) @(posedge clk_sys_i);
		if (r.drop)
		begin
			check("byte ready", 16'h0000, rx_byte_ready_o);
			return;
		end
		check("level hit", eb.size() >= threshold_i[7:4], rx_level_hit_o);
		check("request", 16'h0001, rx_dma_request_o);
		foreach (eb[i])
		begin
			k = 0;
			while (rx_byte_ready_o !== 1'b1 && k < 200)
			begin
				@(posedge clk_sys_i);
				k++;
			end
			check("data", eb[i], rx_data_o);
			data_rd_i <= 1'b1;
			@(posedge clk_sys_i);
			data_rd_i <= 1'b0;
			@(posedge clk_sys_i);
		end
		check("ready after last", 16'h0000, rx_byte_ready_o);
		check("request after last", 16'h0000, rx_dma_request_o);
		check("status", r.status, frame_status_o);
		check("count", eb.size(), byte_count_o);
		check("residue", r.extra, residue_o);
		data_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		data_rd_i <= 1'b0;
		count_lo_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		count_lo_rd_i <= 1'b0;
		check("ready before rearm", 16'h0000, rx_byte_ready_o);
	endtask : run_row
	initial
	begin
		{slot_sync_i, invert_i, mux_mode_i, data_rd_i, count_lo_rd_i, rx_on_i} = 6'h00;
		{ignore_cr_i, reset_n_i} = 2'h0;
		{cmd_ctrl_i, residual_ctrl_i, addr_ctrl_i} = 24'h0000_00;
		{addr0_i, addr1_i, addr2_i, addr3_i} = 32'h4255_6642;
		slot_sel_i = 5'h00;
		min_size_i = 4'h4;
		max_size_i = 8'h20;
		threshold_i = 8'hF0;
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		check("ready at reset", 16'h0000, rx_byte_ready_o);
		check("status at reset", 16'h0000, frame_status_o);
		rx_on_i <= 1'b1;
		foreach (rows[i])
			run_row(rows[i]);
		// Abort in mid-frame, then long mark idle, then recovery
		for (int j = 0; j < 16; j++)
			abort_bits.push_back(j[0]);
		hdlc_line_source_inst.send_flag();
		hdlc_line_source_inst.send_bits(abort_bits);
		hdlc_line_source_inst.send_ones(24);
		repeat (10) @(posedge clk_sys_i);
		check("mark idle", 16'h0001, mark_idle_o);
		check("aborted bytes", 16'h0000, rx_byte_ready_o);
		run_row(rows[0]);
		@(posedge clk_sys_i);
		max_size_i <= 8'h05;
		threshold_i <= 8'h20;
		run_row('{4'h7, 8'hFF, 1'h0, 8'h00, 1'h0, 3'h0, 1'h0, 8'h02});
		end_of_test();
	end
endmodule : hdlc_frame_receiver_bench
`default_nettype wire
